//--- rtl/pcap_config_port.sv
/*
 * pcap_config_port: host I/O address register and data window that turn
 * host I/O accesses into configuration accesses.
 * Other words and partial address accesses pass on as I/O cycles.
 * Assumes one host I/O request at a time, held off until io_ack_out, and
 * a pci master engine plus an internal register file that each answer
 * a request with a one-cycle done strobe.
 */
`default_nettype none

module pcap_config_port (
   input wire logic sys_clk_in, // host clock
   input wire logic rstn_in, // synchronous reset, active low
   // host I/O side
   input wire logic io_req_in, // request pulse
   input wire logic io_wr_in, // 1 = write
   input wire logic [15:0] io_addr_in, // I/O byte address of the dword
   input wire logic [3:0] io_be_in, // byte enables, active high
   input wire logic [31:0] io_wdata_in, // write data
   output logic io_ack_out, // completion pulse
   output logic [31:0] io_rdata_out, // read data
   // pci master engine side
   output pcap_pkg::pcap_pci_req_t pci_req_out, // cycle description
   output logic pci_valid_out, // held until pci_done_in
   input wire logic pci_done_in, // cycle finished
   input wire logic [31:0] pci_rdata_in, // read data, all ones on master abort
   // internal configuration register file
   output logic int_valid_out, // held until int_done_in
   output logic int_wr_out, // 1 = write
   output logic [5:0] int_reg_out, // doubleword register number
   output logic [3:0] int_be_out, // byte enables
   output logic [31:0] int_wdata_out, // write data
   input wire logic int_done_in, // access finished
   input wire logic [31:0] int_rdata_in // read data
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   pcap_pkg::pcap_state_t state_r, state_nxt; // control sequence
   logic [31:0] addr_sel_r, addr_sel_nxt; // config_address_select
   logic [31:0] data_win_r, data_win_nxt; // config_data_window

   // host answer
   logic io_ack_r, io_ack_nxt; // completion strobe
   logic [31:0] rdata_r, rdata_nxt; // returned data

   // engine request, held until done
   pcap_pkg::pcap_pci_req_t pci_req_r, pci_req_nxt; // pending pci cycle
   logic pci_valid_r, pci_valid_nxt; // pci cycle outstanding

   // internal file request
   logic int_valid_r, int_valid_nxt; // internal access outstanding
   logic int_wr_r, int_wr_nxt; // internal write flag
   logic [5:0] int_reg_r, int_reg_nxt; // internal register number
   logic [3:0] int_be_r, int_be_nxt; // internal byte enables
   logic [31:0] int_wdata_r, int_wdata_nxt; // internal write data

   // window access in flight
   logic cfg_access_r, cfg_access_nxt; // current access goes through the window

   // ------------------------------------------------------------
   // address phase formation
   // ------------------------------------------------------------
   logic [pcap_pkg::PCAP_SEL_LINES-1:0] sel; // type 0 select lines
   logic self_hit; // bridge is the target
   logic [31:0] cfg_ad; // address phase value

   // both helpers are plain logic on the registered address

   pcap_idsel_decode #(
      .MAX_DEV(pcap_pkg::PCAP_MAX_DEV)
   ) u_idsel (
      .dev_in(addr_sel_r[pcap_pkg::PCAP_DEV_MSB:pcap_pkg::PCAP_DEV_LSB]),
      .sel_out(sel)
   );

   // encoder also flags the bridge's own function 0
   pcap_cfg_encode u_encode (
      .cfg_in(addr_sel_r),
      .sel_in(sel),
      .self_out(self_hit),
      .ad_out(cfg_ad)
   );

   // ------------------------------------------------------------
   // request decode
   // ------------------------------------------------------------
   // decode terms, from this cycle's request and the held address and window registers
   logic hit_addr_reg; // word of the address register
   logic hit_data_reg; // word of the data window
   logic cfg_enabled; // config_space_enable
   logic [31:0] merged_wdata; // window contents with new bytes laid in

   // bits 1:0 ignored, byte enables pick the lanes
   assign hit_addr_reg = io_addr_in[15:2] == pcap_pkg::PCAP_ADDR_REG_OFS[15:2];
   assign hit_data_reg = io_addr_in[15:2] == pcap_pkg::PCAP_DATA_REG_OFS[15:2];
   assign cfg_enabled = addr_sel_r[pcap_pkg::PCAP_ENABLE_BIT];

   // byte-wise merge so partial window writes keep the other lanes;
   // window writes hand on this word, so lanes left out carry
   // the window's held bytes
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         merged_wdata[8*i +: 8] = io_be_in[i] ? io_wdata_in[8*i +: 8] : data_win_r[8*i +: 8];
      end
   end

   // ------------------------------------------------------------
   // control sequence, next values
   // ------------------------------------------------------------
   // requests count only in idle; while busy they are dropped
   always_comb begin
      state_nxt = state_r;
      addr_sel_nxt = addr_sel_r;
      data_win_nxt = data_win_r;
      io_ack_nxt = 1'b0;
      rdata_nxt = rdata_r;
      pci_req_nxt = pci_req_r;
      pci_valid_nxt = pci_valid_r;
      int_valid_nxt = int_valid_r;
      int_wr_nxt = int_wr_r;
      int_reg_nxt = int_reg_r;
      int_be_nxt = int_be_r;
      int_wdata_nxt = int_wdata_r;
      cfg_access_nxt = cfg_access_r;

      unique case (state_r)
         pcap_pkg::PCAP_ST_IDLE: begin
            if (io_req_in) begin
               // default: plain I/O pass-through at the same address
               pci_req_nxt.cmd = io_wr_in ? pcap_pkg::PCAP_CMD_IO_WR : pcap_pkg::PCAP_CMD_IO_RD;
               pci_req_nxt.addr = {16'h0000, io_addr_in[15:2], 2'h0};
               pci_req_nxt.be = io_be_in;
               pci_req_nxt.data = io_wdata_in;
               cfg_access_nxt = 1'b0;

               if (hit_addr_reg && io_be_in == pcap_pkg::PCAP_BE_DWORD) begin
                  // full dword: claimed and served locally
                  // reserved bits masked, they read zero
                  if (io_wr_in) begin
                     addr_sel_nxt = io_wdata_in & pcap_pkg::PCAP_ADDR_WR_MASK;
                  end
                  // a read sees the value before this access
                  rdata_nxt = addr_sel_r;
                  state_nxt = pcap_pkg::PCAP_ST_ACK;
               end else if (hit_data_reg && cfg_enabled) begin
                  // enabled window: becomes a configuration access
                  cfg_access_nxt = 1'b1;
                  if (io_wr_in) begin
                     data_win_nxt = merged_wdata;
                  end

                  if (self_hit) begin
                     // bridge's own registers, never seen on pci
                     // register number picks the dword
                     int_valid_nxt = 1'b1;
                     int_wr_nxt = io_wr_in;
                     int_reg_nxt = addr_sel_r[pcap_pkg::PCAP_REG_MSB:pcap_pkg::PCAP_REG_LSB];
                     int_be_nxt = io_be_in;
                     int_wdata_nxt = merged_wdata; // lanes off keep window bytes
                     state_nxt = pcap_pkg::PCAP_ST_INT;
                  end else begin
                     // type chosen by bus number, fields from the encoder
                     // bus zero gives type 0, other buses type 1
                     pci_req_nxt.cmd = io_wr_in ? pcap_pkg::PCAP_CMD_CFG_WR
                                                : pcap_pkg::PCAP_CMD_CFG_RD;
                     pci_req_nxt.addr = cfg_ad;
                     pci_req_nxt.data = merged_wdata;
                     pci_valid_nxt = 1'b1;
                     state_nxt = pcap_pkg::PCAP_ST_PCI;
                  end
               end else begin
                  // any access at 0CF8h short of a full dword, disabled window, or any other port
                  // host address and byte enables pass as they are
                  pci_valid_nxt = 1'b1;
                  state_nxt = pcap_pkg::PCAP_ST_PCI;
               end
            end
         end

         pcap_pkg::PCAP_ST_PCI: begin
            // engine always ends a cycle, all ones on abort
            if (pci_done_in) begin
               pci_valid_nxt = 1'b0;
               // for writes the host ignores this word
               rdata_nxt = pci_rdata_in;
               // window mirrors what a configuration read returned
               // so a later partial write starts from those bytes
               if (cfg_access_r && pci_req_r.cmd == pcap_pkg::PCAP_CMD_CFG_RD) begin
                  data_win_nxt = pci_rdata_in;
               end
               state_nxt = pcap_pkg::PCAP_ST_ACK;
            end
         end

         pcap_pkg::PCAP_ST_INT: begin
            // internal file answers like the engine
            if (int_done_in) begin
               int_valid_nxt = 1'b0;
               rdata_nxt = int_rdata_in;
               // reads refresh the window
               if (!int_wr_r) begin
                  data_win_nxt = int_rdata_in;
               end
               state_nxt = pcap_pkg::PCAP_ST_ACK;
            end
         end

         pcap_pkg::PCAP_ST_ACK: begin
            // one-cycle completion, then ready again
            // next request may be taken at the following edge
            io_ack_nxt = 1'b1;
            state_nxt = pcap_pkg::PCAP_ST_IDLE;
         end

         default: begin
            // illegal one-hot code: recover quietly
            state_nxt = pcap_pkg::PCAP_ST_IDLE;
            pci_valid_nxt = 1'b0;
            int_valid_nxt = 1'b0;
         end
      endcase
   end

   // ------------------------------------------------------------
   // control sequence, registers
   // ------------------------------------------------------------
   // synchronous reset puts the state in idle and clears every other flop, outputs read zero
   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         // idle, both host registers zero
         state_r <= pcap_pkg::PCAP_ST_IDLE;
         addr_sel_r <= pcap_pkg::PCAP_ADDR_RST;
         data_win_r <= pcap_pkg::PCAP_DATA_RST;
         io_ack_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         // engine and internal requests
         pci_req_r <= '0;
         pci_valid_r <= 1'b0;
         int_valid_r <= 1'b0;
         int_wr_r <= 1'b0;
         int_reg_r <= 6'h00;
         int_be_r <= 4'h0;
         int_wdata_r <= 32'h0000_0000;
         cfg_access_r <= 1'b0;
      end else begin
         // plain registering of the next values
         state_r <= state_nxt;
         addr_sel_r <= addr_sel_nxt;
         data_win_r <= data_win_nxt;
         io_ack_r <= io_ack_nxt;
         rdata_r <= rdata_nxt;
         pci_req_r <= pci_req_nxt;
         pci_valid_r <= pci_valid_nxt;
         int_valid_r <= int_valid_nxt;
         int_wr_r <= int_wr_nxt;
         int_reg_r <= int_reg_nxt;
         int_be_r <= int_be_nxt;
         int_wdata_r <= int_wdata_nxt;
         cfg_access_r <= cfg_access_nxt;
      end
   end

   // ------------------------------------------------------------
   // outputs, all straight from flops
   // ------------------------------------------------------------
   // no logic between flops and pins
   assign io_ack_out = io_ack_r;
   assign io_rdata_out = rdata_r;

   assign pci_req_out = pci_req_r;
   assign pci_valid_out = pci_valid_r;

   assign int_valid_out = int_valid_r;
   assign int_wr_out = int_wr_r;
   assign int_reg_out = int_reg_r;
   assign int_be_out = int_be_r;
   assign int_wdata_out = int_wdata_r;

endmodule

`default_nettype wire

//--- rtl/pcap_pkg.sv
/*
 * pcap_pkg: shared constants and types of the configuration access port.
 * Assumes a host I/O bus that presents dword addresses with byte enables
 * and a PCI master engine that runs the cycles this block describes.
 */
`default_nettype none

package pcap_pkg;

   // ------------------------------------------------------------
   // host I/O locations
   // ------------------------------------------------------------
   localparam logic [15:0] PCAP_ADDR_REG_OFS = 16'h0CF8; // config_address_select
   localparam logic [15:0] PCAP_DATA_REG_OFS = 16'h0CFC; // config_data_window
   localparam logic [3:0] PCAP_BE_DWORD = 4'hF; // all four lanes

   // ------------------------------------------------------------
   // config_address_select fields
   // ------------------------------------------------------------
   localparam int PCAP_ENABLE_BIT = 31; // config_space_enable
   localparam int PCAP_BUS_MSB = 23; // target_bus_field
   localparam int PCAP_BUS_LSB = 16;
   localparam int PCAP_DEV_MSB = 15; // target_device_field
   localparam int PCAP_DEV_LSB = 11;
   localparam int PCAP_FUNC_MSB = 10; // target_function_field
   localparam int PCAP_FUNC_LSB = 8;
   localparam int PCAP_REG_MSB = 7; // target_register_field
   localparam int PCAP_REG_LSB = 2;
   localparam logic [31:0] PCAP_ADDR_WR_MASK = 32'h80FF_FFFC; // reserved bits stay zero

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [31:0] PCAP_ADDR_RST = 32'h0000_0000;
   localparam logic [31:0] PCAP_DATA_RST = 32'h0000_0000;

   // ------------------------------------------------------------
   // cycle encodings
   // ------------------------------------------------------------
   localparam logic [1:0] PCAP_TYPE1_CODE = 2'h1; // ad[1:0] of a type 1 cycle
   localparam logic [1:0] PCAP_TYPE0_CODE = 2'h0;
   localparam int PCAP_MAX_DEV = 20; // highest device with a select line
   localparam int PCAP_SEL_LINES = 21; // ad[31:11]
   localparam logic [7:0] PCAP_BUS_ZERO = 8'h00;
   localparam logic [4:0] PCAP_SELF_DEV = 5'h00;
   localparam logic [2:0] PCAP_SELF_FUNC = 3'h0;

   // pci bus commands
   typedef enum logic [3:0] {
      PCAP_CMD_IO_RD = 4'h2,
      PCAP_CMD_IO_WR = 4'h3,
      PCAP_CMD_CFG_RD = 4'hA,
      PCAP_CMD_CFG_WR = 4'hB
   } pcap_cmd_t;

   // request handed to the pci master engine
   typedef struct packed {
      pcap_cmd_t cmd; // bus command
      logic [31:0] addr; // ad lines in the address phase
      logic [3:0] be; // byte enables, active high
      logic [31:0] data; // write data
   } pcap_pci_req_t;

   // control state machine, one-hot
   typedef enum logic [3:0] {
      PCAP_ST_IDLE = 4'h1,
      PCAP_ST_PCI = 4'h2,
      PCAP_ST_INT = 4'h4,
      PCAP_ST_ACK = 4'h8
   } pcap_state_t;

endpackage

`default_nettype wire

//--- rtl/pcap_idsel_decode.sv
/*
 * pcap_idsel_decode: turns a device number into the at most one-hot select lines
 * ad[31:11] of a type 0 configuration cycle.
 * Assumes the caller uses the result only for type 0 cycles.
 */
`default_nettype none

module pcap_idsel_decode #(
   parameter int MAX_DEV = pcap_pkg::PCAP_MAX_DEV
) (
   input wire logic [4:0] dev_in, // target device number
   output logic [pcap_pkg::PCAP_SEL_LINES-1:0] sel_out // ad[31:11]
);

   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   // device n lifts ad[11+n]; ad11 and devices above the limit stay low
   always_comb begin
      sel_out = '0;
      if (dev_in != pcap_pkg::PCAP_SELF_DEV && int'(dev_in) <= MAX_DEV) begin
         sel_out[dev_in] = 1'b1;
      end
   end

endmodule

`default_nettype wire

//--- rtl/pcap_cfg_encode.sv
/*
 * pcap_cfg_encode: forms the address phase of a configuration cycle from
 * the address register, and flags accesses the bridge serves itself.
 * Assumes sel_in comes from the select decoder for the same device number.
 */
`default_nettype none

module pcap_cfg_encode (
   input wire logic [31:0] cfg_in, // address register contents
   input wire logic [pcap_pkg::PCAP_SEL_LINES-1:0] sel_in, // decoded selects
   output logic self_out, // bridge itself is the target
   output logic [31:0] ad_out // address phase value
);

   logic [7:0] bus; // target_bus_field
   logic [4:0] dev; // target_device_field
   logic [2:0] func; // target_function_field
   logic [5:0] regn; // target_register_field

   assign bus = cfg_in[pcap_pkg::PCAP_BUS_MSB:pcap_pkg::PCAP_BUS_LSB];
   assign dev = cfg_in[pcap_pkg::PCAP_DEV_MSB:pcap_pkg::PCAP_DEV_LSB];
   assign func = cfg_in[pcap_pkg::PCAP_FUNC_MSB:pcap_pkg::PCAP_FUNC_LSB];
   assign regn = cfg_in[pcap_pkg::PCAP_REG_MSB:pcap_pkg::PCAP_REG_LSB];

   // ------------------------------------------------------------
   // address phase
   // ------------------------------------------------------------
   // non-self function numbers of device 0 fall to a select-less type 0
   always_comb begin
      self_out = (bus == pcap_pkg::PCAP_BUS_ZERO) && (dev == pcap_pkg::PCAP_SELF_DEV)
                 && (func == pcap_pkg::PCAP_SELF_FUNC);
      if (bus != pcap_pkg::PCAP_BUS_ZERO) begin
         // type 1: upper lines zero, bus and device copied through
         ad_out = {8'h00, bus, dev, func, regn, pcap_pkg::PCAP_TYPE1_CODE};
      end else begin
         // type 0: at most one select line, then function and register
         ad_out = {sel_in, func, regn, pcap_pkg::PCAP_TYPE0_CODE};
      end
   end

endmodule

`default_nettype wire

//--- tb/pcap_config_port_asserts.sv
/*
 * pcap_config_port_asserts: timing and address-phase checks on the
 * configuration access port, bound to its top module.
 * Assumes the host keeps at most one request outstanding.
 */
`default_nettype none

module pcap_asserts (
   input wire logic sys_clk_in,
   input wire logic rstn_in,
   input wire logic io_req_in,
   input wire logic [15:0] io_addr_in,
   input wire logic [3:0] io_be_in,
   input wire logic io_ack_out,
   input wire pcap_pkg::pcap_pci_req_t pci_req_out,
   input wire logic pci_valid_out,
   input wire logic pci_done_in,
   input wire logic int_valid_out,
   input wire logic int_done_in
);
   // ---------------------------------------------
   // shared terms
   // ---------------------------------------------
   default clocking @(posedge sys_clk_in);
   endclocking
   default disable iff (!rstn_in);
   logic addr_hit; // request aimed at the address register
   logic cfg_cyc; // configuration cycle offered to the engine
   assign addr_hit = io_req_in && io_addr_in[15:2] == pcap_pkg::PCAP_ADDR_REG_OFS[15:2];
   assign cfg_cyc = pci_valid_out && pci_req_out.cmd[3];

   // ---------------------------------------------
   // assertions
   // ---------------------------------------------
   local_ack_a: assert property (addr_hit && io_be_in == pcap_pkg::PCAP_BE_DWORD |=>
      !pci_valid_out && !int_valid_out ##1 io_ack_out) else $error("local access not acked");
   pass_through_a: assert property (addr_hit && io_be_in != pcap_pkg::PCAP_BE_DWORD |=>
      pci_valid_out && !pci_req_out.cmd[3]) else $error("partial access not forwarded");
   type1_phase_a: assert property (cfg_cyc && pci_req_out.addr[1:0] == 2'h1 |->
      pci_req_out.addr[31:24] == 8'h00 && pci_req_out.addr[23:16] != 8'h00)
      else $error("type 1 address phase wrong");
   type0_select_a: assert property (cfg_cyc && pci_req_out.addr[1:0] == 2'h0 |->
      $onehot0(pci_req_out.addr[31:11]) && !pci_req_out.addr[11])
      else $error("type 0 select not one-hot");
   req_hold_a: assert property (pci_valid_out && !pci_done_in |=>
      pci_valid_out && $stable(pci_req_out)) else $error("engine request moved");
   pci_end_a: assert property (pci_valid_out && pci_done_in |=>
      !pci_valid_out ##1 io_ack_out) else $error("engine completion not acked");
   int_end_a: assert property (int_valid_out && int_done_in |=>
      !int_valid_out ##1 io_ack_out) else $error("internal completion not acked");
   ack_pulse_a: assert property (io_ack_out |=> !io_ack_out) else $error("ack longer than one");
   path_excl_a: assert property (!(pci_valid_out && int_valid_out))
      else $error("internal access also sent to pci");

   // coverage of the main paths
   cover property (cfg_cyc && pci_done_in);
   cover property (int_valid_out && int_done_in);
   cover property (addr_hit && io_be_in == pcap_pkg::PCAP_BE_DWORD);
endmodule

bind pcap_config_port pcap_asserts u_chk (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
   .io_req_in(io_req_in), .io_addr_in(io_addr_in), .io_be_in(io_be_in),
   .io_ack_out(io_ack_out), .pci_req_out(pci_req_out), .pci_valid_out(pci_valid_out),
   .pci_done_in(pci_done_in), .int_valid_out(int_valid_out), .int_done_in(int_done_in));

`default_nettype wire

//--- tb/pcap_far_model.sv
/*
 * pcap_far_model: pci master engine and internal register file stand-in.
 * Assumes the port holds each valid until the done strobe was seen.
 */
`default_nettype none

module pcap_far_model (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic slow_in, // stretch every answer
   input wire pcap_pkg::pcap_pci_req_t pci_req_in,
   input wire logic pci_valid_in,
   output logic pci_done_out,
   output logic [31:0] pci_rdata_out,
   input wire logic int_valid_in,
   input wire logic int_wr_in,
   input wire logic [5:0] int_reg_in,
   input wire logic [3:0] int_be_in,
   input wire logic [31:0] int_wdata_in,
   output logic int_done_out,
   output logic [31:0] int_rdata_out
);
   timeunit 1ns;
   timeprecision 100ps;
   // ---------------------------------------------
   // answer timing and storage
   // ---------------------------------------------
   logic [3:0] pcnt_r, icnt_r; // cycles a request has waited
   logic [31:0] regs_r [64]; // internal dwords
   logic [3:0] wait_v; // answer delay
   assign wait_v = slow_in ? 4'h6 : 4'h0;

   // released data toggles so a stale value is never mistaken for an answer
   always @(posedge clk_in) begin
      pci_done_out <= 1'b0;
      int_done_out <= 1'b0;
      pci_rdata_out <= ~pci_rdata_out;
      int_rdata_out <= ~int_rdata_out;
      pcnt_r <= pci_valid_in ? pcnt_r + 4'h1 : 4'h0;
      icnt_r <= int_valid_in ? icnt_r + 4'h1 : 4'h0;
      if (!rstn_in) begin
         pcnt_r <= 4'h0;
         icnt_r <= 4'h0;
         pci_rdata_out <= 32'h0;
         int_rdata_out <= 32'h0;
         regs_r <= '{default: 32'h0};
      end
      if (rstn_in && pci_valid_in && pcnt_r == wait_v) begin
         pci_done_out <= 1'b1;
         // type 0 with no select line ends in master abort
         pci_rdata_out <= (pci_req_in.cmd[3] && pci_req_in.addr[1:0] == 2'h0 &&
            pci_req_in.addr[31:11] == 21'h0) ? 32'hFFFF_FFFF : ~pci_req_in.addr;
      end
      if (rstn_in && int_valid_in && icnt_r == wait_v) begin
         int_done_out <= 1'b1;
         int_rdata_out <= regs_r[int_reg_in];
         for (int b = 0; b < 4; b++) begin
            if (int_wr_in && int_be_in[b]) begin
               regs_r[int_reg_in][8*b +: 8] <= int_wdata_in[8*b +: 8];
            end
         end
      end
   end
endmodule

`default_nettype wire

//--- tb/tb_pci_config_access_port.sv
/*
 * tb_pci_config_access_port: host I/O sequences against the port.
 * Assumes the far model answers engine and internal requests.
 */
`default_nettype none

module tb_pci_config_access_port;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [15:0] ADR = pcap_pkg::PCAP_ADDR_REG_OFS;
   localparam logic [15:0] DAT = pcap_pkg::PCAP_DATA_REG_OFS;
   logic sys_clk_in = 1'b0, rstn_in = 1'b0, io_req_in = 1'b0, io_wr_in = 1'b0, slow = 1'b0;
   logic [15:0] io_addr_in = 16'h0;
   logic [3:0] io_be_in = 4'h0, int_be_out;
   logic [31:0] io_wdata_in = 32'h0, io_rdata_out, pci_rdata_in, int_wdata_out, int_rdata_in;
   logic io_ack_out, pci_valid_out, pci_done_in, int_valid_out, int_wr_out, int_done_in;
   logic [5:0] int_reg_out;
   logic [31:0] rd, cfg_v [5], ad_v [5];
   pcap_pkg::pcap_pci_req_t pci_req_out, seen_q;
   int fails = 0, checks_done = 0, pci_cnt = 0, int_cnt = 0, p0;

   always #12.5 sys_clk_in = ~sys_clk_in;

   pcap_config_port uut (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .io_req_in(io_req_in),
      .io_wr_in(io_wr_in), .io_addr_in(io_addr_in), .io_be_in(io_be_in),
      .io_wdata_in(io_wdata_in), .io_ack_out(io_ack_out), .io_rdata_out(io_rdata_out),
      .pci_req_out(pci_req_out), .pci_valid_out(pci_valid_out), .pci_done_in(pci_done_in),
      .pci_rdata_in(pci_rdata_in), .int_valid_out(int_valid_out), .int_wr_out(int_wr_out),
      .int_reg_out(int_reg_out), .int_be_out(int_be_out), .int_wdata_out(int_wdata_out),
      .int_done_in(int_done_in), .int_rdata_in(int_rdata_in));
   pcap_far_model far (.clk_in(sys_clk_in), .rstn_in(rstn_in), .slow_in(slow),
      .pci_req_in(pci_req_out), .pci_valid_in(pci_valid_out), .pci_done_out(pci_done_in),
      .pci_rdata_out(pci_rdata_in), .int_valid_in(int_valid_out), .int_wr_in(int_wr_out),
      .int_reg_in(int_reg_out), .int_be_in(int_be_out), .int_wdata_in(int_wdata_out),
      .int_done_out(int_done_in), .int_rdata_out(int_rdata_in));

   // ---------------------------------------------
   // capture of completed far-side requests
   // ---------------------------------------------
   always @(posedge sys_clk_in) begin
      if (pci_valid_out && pci_done_in) begin
         seen_q = pci_req_out;
         pci_cnt++;
      end
      if (int_valid_out && int_done_in) begin
         int_cnt++;
      end
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // one host I/O access; the wait for ack is bounded
   task automatic io(input logic wr, input logic [15:0] a, input logic [3:0] be,
      input logic [31:0] wd);
      int n;
      @(posedge sys_clk_in);
      #2;
      io_req_in = 1'b1;
      io_wr_in = wr;
      io_addr_in = a;
      io_be_in = be;
      io_wdata_in = wd;
      @(posedge sys_clk_in);
      #2;
      io_req_in = 1'b0;
      n = 0;
      while (io_ack_out !== 1'b1 && n < 64) begin
         @(posedge sys_clk_in);
         #1;
         n++;
      end
      if (io_ack_out !== 1'b1) begin
         chk("io_ack_out", 32'h1, 32'h0);
         end_of_test();
      end
      rd = io_rdata_out;
   endtask

   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial begin
      cfg_v = '{32'h8003_2A1C, 32'h8000_090C, 32'h8000_A0FC, 32'h8000_A804, 32'h8000_0300};
      ad_v = '{32'h0003_2A1D, 32'h0000_110C, 32'h8000_00FC, 32'h0000_0004, 32'h0000_0300};
      repeat (2) @(posedge sys_clk_in);
      #1;
      chk("outputs in reset", 32'h0, {io_ack_out, pci_valid_out, int_valid_out});
      #1;
      rstn_in = 1'b1;
      io(1'b0, ADR, 4'hF, 32'h0);
      chk("address reg reset", pcap_pkg::PCAP_ADDR_RST, rd);
      io(1'b1, ADR, 4'hF, 32'hFFFF_FFFF);
      io(1'b0, ADR, 4'hF, 32'h0);
      chk("address reg mask", 32'h80FF_FFFC, rd);
      io(1'b1, ADR, 4'h1, 32'h0);
      chk("partial cmd", pcap_pkg::PCAP_CMD_IO_WR, seen_q.cmd);
      chk("partial addr", 32'h0000_0CF8, seen_q.addr);
      chk("partial be", 32'h1, seen_q.be);
      io(1'b0, ADR, 4'hF, 32'h0);
      chk("address reg kept", 32'h80FF_FFFC, rd);
      io(1'b1, ADR, 4'hF, 32'h0000_0104);
      io(1'b0, DAT, 4'hF, 32'h0);
      chk("disabled cmd", pcap_pkg::PCAP_CMD_IO_RD, seen_q.cmd);
      chk("disabled addr", 32'h0000_0CFC, seen_q.addr);
      io(1'b1, ADR, 4'hF, cfg_v[0]);
      io(1'b1, DAT, 4'h2, 32'hFFFF_AB00);
      chk("window reset lanes", 32'h0000_AB00, seen_q.data);
      for (int i = 0; i < 5; i++) begin
         slow = i[0];
         io(1'b1, ADR, 4'hF, cfg_v[i]);
         io(1'b0, DAT, 4'hF, 32'h0);
         chk("cfg read cmd", pcap_pkg::PCAP_CMD_CFG_RD, seen_q.cmd);
         chk("cfg address phase", ad_v[i], seen_q.addr);
         chk("cfg read data", ad_v[i][31:11] == 21'h0 ? 32'hFFFF_FFFF : ~ad_v[i], rd);
         io(1'b1, DAT, 4'hF, 32'h1234_5678);
         chk("cfg write cmd", pcap_pkg::PCAP_CMD_CFG_WR, seen_q.cmd);
         chk("cfg write data", 32'h1234_5678, seen_q.data);
      end
      p0 = pci_cnt;
      io(1'b1, ADR, 4'hF, 32'h8000_0010);
      io(1'b1, DAT, 4'hF, 32'hA5C3_0F96);
      io(1'b1, DAT, 4'h2, 32'h0000_5A00);
      io(1'b0, DAT, 4'hF, 32'h0);
      chk("internal data", 32'hA5C3_5A96, rd);
      chk("internal count", 32'h3, int_cnt);
      chk("no pci for self", p0, pci_cnt);
      end_of_test();
   end
endmodule

`default_nettype wire
